//--- mpm_mac_ctrl.sv
// Purpose: apb control slice: tx queue, address match, phy mgmt, status
// Assumes: pclk 25 MHz, apb always ready, single clock domain
// Notes:   mdio is split into input, output and enable
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module mpm_mac_ctrl
    import mpm_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             rx_da_valid,
    input  wire logic [47:0]      rx_da,
    output logic                  rx_match_q,
    output logic                  rx_to_screen_q,
    output logic                  tx_en_q,
    input  wire logic             tx_desc_adv,
    input  wire logic             tx_desc_wrap,
    output logic      [31:0]      tx_desc_addr_q,
    input  wire logic [16:0]      ext_events,
    output logic                  irq,
    input  wire logic             mdio_in,
    output mpm_pkg::mpm_mdio_t    mdio_pins
);
    import mpm_pkg::*;

    logic [31:0]        ctrl_q;
    logic [31:0]        cfg_q;
    logic [31:0]        txq_q;
    logic [IRQ_NUM-1:0] isr_q;
    logic [IRQ_NUM-1:0] isr_d;
    logic [31:0]        hash_lo_q;
    logic [31:0]        hash_hi_q;
    logic [31:0]        sa_lo_q [NUM_SA];
    logic [31:0]        sa_hi_q [NUM_SA];
    logic [NUM_SA-1:0]  sa_en_q;
    logic               hash_en_q;
    logic [7:0]         addr;
    logic               wr_acc;
    logic               rd_acc;
    logic               mapped;
    logic [31:0]        rd_mux;
    logic [NUM_SA-1:0]  sa_lo_hit;
    logic [NUM_SA-1:0]  sa_hi_hit;
    logic [NUM_SA-1:0]  sa_match;
    logic [5:0]         hash_idx;
    logic               hash_match;
    logic               any_match;
    logic               mgmt_start;
    logic [31:0]        mgmt_word;
    logic               mgmt_busy;
    logic               mgmt_done;
    logic [IRQ_NUM-1:0] ev_set;

    assign addr    = paddr[7:0];
    assign pready  = 1'b1;
    assign wr_acc  = psel && penable && pwrite && mapped;
    assign rd_acc  = psel && penable && !pwrite && mapped;

    // folds the destination address into a 6-bit hash index
    function automatic logic [5:0] hash_of(input logic [47:0] da);
        logic [5:0] h;
        h = 6'h00;
        for (int i = 0; i < 8; i++) begin
            h = h ^ da[i*6 +: 6];
        end
        return h;
    endfunction : hash_of

    function automatic logic [7:0] sa_off(input int unsigned idx,
                                          input logic [7:0] base);
        return base + 8'(idx) * SA_STRIDE;
    endfunction : sa_off

    always_comb begin
        for (int i = 0; i < NUM_SA; i++) begin
            sa_lo_hit[i] = addr == sa_off(i, OFF_SA1_LO);
            sa_hi_hit[i] = addr == sa_off(i, OFF_SA1_HI);
        end
    end

    // register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            cfg_q  <= CFG_RST;
            txq_q  <= TXQ_RST;
        end else if (wr_acc) begin
            if (addr == OFF_CTRL) ctrl_q <= pwdata;
            if (addr == OFF_CFG)  cfg_q  <= pwdata;
            if (addr == OFF_TXQ)  txq_q  <= pwdata;
        end
    end

    // pairs accept writes whatever the receive state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hash_lo_q <= 32'h0000_0000;
            hash_hi_q <= 32'h0000_0000;
            hash_en_q <= 1'b0;
            sa_en_q   <= '0;
            for (int i = 0; i < NUM_SA; i++) begin
                sa_lo_q[i] <= 32'h0000_0000;
                sa_hi_q[i] <= 32'h0000_0000;
            end
        end else if (wr_acc) begin
            if (addr == OFF_HASH_LO) begin
                hash_lo_q <= pwdata;
                hash_en_q <= 1'b0;
            end
            if (addr == OFF_HASH_HI) begin
                hash_hi_q <= pwdata;
                hash_en_q <= 1'b1;
            end
            for (int i = 0; i < NUM_SA; i++) begin
                if (sa_lo_hit[i]) begin
                    sa_lo_q[i] <= pwdata;
                    sa_en_q[i] <= 1'b0;
                end
                if (sa_hi_hit[i]) begin
                    sa_hi_q[i] <= pwdata;
                    sa_en_q[i] <= 1'b1;
                end
            end
        end
    end

    // address match, first filter stage
    always_comb begin
        for (int i = 0; i < NUM_SA; i++) begin
            sa_match[i] = sa_en_q[i] &&
                rx_da == {sa_hi_q[i][15:0], sa_lo_q[i]};
        end
    end
    assign hash_idx   = hash_of(rx_da);
    assign hash_match = hash_en_q && cfg_q[CFG_HASH_BIT] &&
                        (hash_idx[5] ? hash_hi_q[hash_idx[4:0]]
                                     : hash_lo_q[hash_idx[4:0]]);
    assign any_match  = (|sa_match) || hash_match;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_match_q     <= 1'b0;
            rx_to_screen_q <= 1'b0;
        end else begin
            if (rx_da_valid) rx_match_q <= any_match;
            rx_to_screen_q <= rx_da_valid && any_match;
        end
    end

    // transmit enable and descriptor walk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_en_q        <= 1'b0;
            tx_desc_addr_q <= 32'h0000_0000;
        end else begin
            tx_en_q <= ctrl_q[CTRL_TXEN_BIT];
            if (ctrl_q[CTRL_TXEN_BIT] && !tx_en_q) begin
                tx_desc_addr_q <= txq_q;
            end else if (tx_desc_adv) begin
                tx_desc_addr_q <= tx_desc_wrap ? txq_q
                                : tx_desc_addr_q + DESC_BYTES;
            end
        end
    end

    // phy management
    assign mgmt_start = wr_acc && addr == OFF_MAINT;
    mpm_mdio_shift u_shift (
        .pclk      (pclk),
        .presetn   (presetn),
        .start     (mgmt_start),
        .load_word (pwdata),
        .div_sel   (cfg_q[CFG_DIV_LSB +: CFG_DIV_W]),
        .mdio_in   (mdio_in),
        .pins      (mdio_pins),
        .shift_q   (mgmt_word),
        .busy_q    (mgmt_busy),
        .done      (mgmt_done)
    );

    // interrupt status; a new event beats a same-cycle clear
    assign ev_set = {ext_events, mgmt_done};
    always_comb begin
        isr_d = isr_q;
        if (addr == OFF_ISR) begin
            if (cfg_q[CFG_WC_BIT] && wr_acc)
                isr_d = isr_q & ~pwdata[IRQ_NUM-1:0];
            else if (!cfg_q[CFG_WC_BIT] && rd_acc)
                isr_d = '0;
        end
        isr_d = isr_d | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) isr_q <= '0;
        else          isr_q <= isr_d;
    end
    assign irq = |isr_q;

    // read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b1;
        unique case (addr)
            OFF_CTRL:    rd_mux = ctrl_q;
            OFF_CFG:     rd_mux = cfg_q;
            OFF_STAT:    rd_mux[STAT_IDLE_BIT] = !mgmt_busy;
            OFF_TXQ:     rd_mux = txq_q;
            OFF_ISR:     rd_mux[IRQ_NUM-1:0] = isr_q;
            OFF_MAINT:   rd_mux = mgmt_word;
            OFF_HASH_LO: rd_mux = hash_lo_q;
            OFF_HASH_HI: rd_mux = hash_hi_q;
            default: begin
                mapped = 1'b0;
                for (int i = 0; i < NUM_SA; i++) begin
                    if (sa_lo_hit[i]) begin
                        rd_mux = sa_lo_q[i];
                        mapped = 1'b1;
                    end
                    if (sa_hi_hit[i]) begin
                        rd_mux = sa_hi_q[i];
                        mapped = 1'b1;
                    end
                end
            end
        endcase
        if (paddr[31:8] != 24'h00_0000 || paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite) prdata <= rd_mux;
    end
    assign pslverr = psel && penable && !mapped;

    logic [31:0] mt_ld_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)        mt_ld_q <= 32'h0000_0000;
        else if (mgmt_start) mt_ld_q <= pwdata;
    end
    logic [11:0] op_cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)        op_cnt_q <= 12'h000;
        else if (mgmt_start) op_cnt_q <= 12'h000;
        else if (mgmt_busy)  op_cnt_q <= op_cnt_q + 12'h001;
    end

    sequence s_lo_write(int k);
        wr_acc && sa_lo_hit[k];
    endsequence
    sequence s_hi_write(int k);
        wr_acc && sa_hi_hit[k];
    endsequence

    property p_sa_suspend;
        @(posedge pclk) disable iff (!presetn)
        s_lo_write(0) |=> !sa_en_q[0] until_with (wr_acc && sa_hi_hit[0]);
    endproperty
    a_sa_suspend: assert property (p_sa_suspend)
        else $error("pair stayed enabled after lower write");

    property p_sa_resume;
        @(posedge pclk) disable iff (!presetn)
        s_hi_write(0) |=> sa_en_q[0] && sa_hi_q[0] == $past(pwdata);
    endproperty
    a_sa_resume: assert property (p_sa_resume)
        else $error("pair not resumed by upper write");

    property p_screen_gate;
        @(posedge pclk) disable iff (!presetn)
        rx_to_screen_q |-> $past(rx_da_valid) && rx_match_q;
    endproperty
    a_screen_gate: assert property (p_screen_gate)
        else $error("frame passed without address match");

    property p_idle_low;
        @(posedge pclk) disable iff (!presetn)
        mgmt_start |=> mgmt_busy until_with mgmt_done;
    endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("idle flag set before shift end");

    property p_start_busy;
        @(posedge pclk) disable iff (!presetn)
        mgmt_start |=> mgmt_busy;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("maintenance write did not start a shift");

    property p_done_irq;
        @(posedge pclk) disable iff (!presetn)
        mgmt_done && !mgmt_start |=> isr_q[IRQ_MGMT_BIT] && !mgmt_busy;
    endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("mgmt interrupt not with idle flag");

    property p_op_time;
        @(posedge pclk) disable iff (!presetn)
        mgmt_done && cfg_q[CFG_DIV_LSB +: CFG_DIV_W] == DIV_NOMINAL |->
            op_cnt_q >= 12'(MGMT_NOM_CYC - MGMT_TOL_CYC) &&
            op_cnt_q <= 12'(MGMT_NOM_CYC + MGMT_TOL_CYC);
    endproperty
    a_op_time: assert property (p_op_time)
        else $error("mgmt operation time off nominal");

    property p_restore;
        @(posedge pclk) disable iff (!presetn)
        mgmt_done |=> mgmt_word[31:16] == mt_ld_q[31:16] &&
            (mgmt_word[15:0] == mt_ld_q[15:0] || mt_ld_q[29:28] == OP_READ);
    endproperty
    a_restore: assert property (p_restore)
        else $error("frame not restored");

    property p_irq_or;
        @(posedge pclk) disable iff (!presetn)
        (|ev_set) |=> irq;
    endproperty
    a_irq_or: assert property (p_irq_or)
        else $error("event seen but interrupt low");

    property p_rc;
        @(posedge pclk) disable iff (!presetn)
        rd_acc && addr == OFF_ISR && !cfg_q[CFG_WC_BIT] && !(|ev_set)
            |=> isr_q == '0;
    endproperty
    a_rc: assert property (p_rc)
        else $error("status not cleared on read");

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        tx_desc_adv && tx_desc_wrap && tx_en_q |=> tx_desc_addr_q == txq_q;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap did not return to list base");
endmodule : mpm_mac_ctrl
`default_nettype wire

//--- mpm_mdio_shift.sv
// Purpose: management frame shifter, preamble then 32 rotating bits
// Assumes: mdio input asynchronous, synchronised here
// Notes:   rotation restores the word; read data replaces low half
`timescale 1ns/1ps
`default_nettype none
module mpm_mdio_shift
    import mpm_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             start,
    input  wire logic [31:0]      load_word,
    input  wire logic [2:0]       div_sel,
    input  wire logic             mdio_in,
    output mpm_pkg::mpm_mdio_t    pins,
    output logic      [31:0]      shift_q,
    output logic                  busy_q,
    output logic                  done
);
    logic       in_s1_q;
    logic       in_s2_q;
    logic       mdc_q;
    logic [7:0] hcnt_q;
    logic [5:0] bit_q;
    logic       tick;
    logic       fall;
    logic       rd_op_q;
    logic       is_read;
    logic [4:0] pos;
    logic       from_pin;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_s1_q <= 1'b0;
            in_s2_q <= 1'b0;
        end else begin
            in_s1_q <= mdio_in;
            in_s2_q <= in_s1_q;
        end
    end

    // op is latched at launch, the rotating word no longer holds it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)   rd_op_q <= 1'b0;
        else if (start) rd_op_q <= load_word[MT_OP_LSB +: 2] == OP_READ;
    end

    assign tick     = busy_q && (hcnt_q == mpm_mdc_half(div_sel) - 8'h01);
    assign fall     = tick && mdc_q;
    assign done     = fall && (bit_q == 6'h3f);
    assign is_read  = rd_op_q;
    assign pos      = bit_q[4:0];
    // the pin feeds the lsb only for the data bits of a read
    assign from_pin = is_read && pos[4];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hcnt_q <= 8'h00;
            mdc_q  <= 1'b0;
        end else if (start) begin
            hcnt_q <= 8'h00;
            mdc_q  <= 1'b0;
        end else if (tick) begin
            hcnt_q <= 8'h00;
            mdc_q  <= !mdc_q;
        end else if (busy_q) begin
            hcnt_q <= hcnt_q + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            bit_q  <= 6'h00;
        end else if (start) begin
            busy_q <= 1'b1;
            bit_q  <= 6'h00;
        end else if (done) begin
            busy_q <= 1'b0;
        end else if (fall) begin
            bit_q  <= bit_q + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= 32'h0000_0000;
        end else if (start) begin
            shift_q <= load_word;
        // moves on mdc fall so the phy samples a settled bit on rise
        end else if (fall && bit_q[5]) begin
            shift_q <= {shift_q[30:0],
                        from_pin ? in_s2_q : shift_q[31]};
        end
    end

    always_comb begin
        pins.mdc     = mdc_q;
        pins.mdio_o  = bit_q[5] ? shift_q[31] : 1'b1;
        pins.mdio_oe = busy_q && !(is_read && bit_q[5] && pos >= 5'd14);
    end
endmodule : mpm_mdio_shift
`default_nettype wire

//--- mpm_phy_model.sv
// Purpose: behavioural phy on the management link
// Assumes: mdio has a pull-up; frames start with a pulse on start
// Notes:   answers read frames with rd_data, captures the last 32 bits
`timescale 1ns/1ps
`default_nettype none
module mpm_phy_model
    import mpm_pkg::*;
(
    input  wire logic               presetn,
    input  wire logic               start,
    input  wire mpm_pkg::mpm_mdio_t pins,
    input  wire logic [15:0]        rd_data,
    output logic                    mdio_wire,
    output logic      [31:0]        cap_q
);
    import mpm_pkg::*;
    int   cnt;
    int   idx;
    logic phy_oe = 1'b0;
    logic phy_o  = 1'b1;

    // released line floats to the pull-up level
    assign mdio_wire = pins.mdio_oe ? pins.mdio_o : (phy_oe ? phy_o : 1'b1);

    always @(posedge start or negedge presetn) begin
        cnt    = 0;
        phy_oe = 1'b0;
    end

    always @(posedge pins.mdc) begin
        cnt++;
        cap_q = {cap_q[30:0], mdio_wire};
    end

    // drive on mdc fall: turnaround zero then data, read frames only
    always @(negedge pins.mdc) begin
        idx    = cnt - 32;
        // op bits slide up the capture as the frame goes on
        phy_oe = (idx >= 15) && (idx <= 31) &&
                 (cap_q[idx-3 -: 2] == OP_READ);
        phy_o  = (idx >= 16 && idx <= 31) ? rd_data[31 - idx] : 1'b0;
    end
endmodule : mpm_phy_model
`default_nettype wire

//--- mpm_pkg.sv
// Purpose: shared constants and types for the mac management slice
// Assumes: 32-bit apb data, byte offsets below 0x100
// Notes:   all offsets are byte addresses of aligned words
package mpm_pkg;
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0] OFF_CTRL       = 8'h00;
    localparam logic [7:0] OFF_CFG        = 8'h04;
    localparam logic [7:0] OFF_STAT       = 8'h08;
    localparam logic [7:0] OFF_TXQ        = 8'h1c;
    localparam logic [7:0] OFF_ISR        = 8'h24;
    localparam logic [7:0] OFF_MAINT      = 8'h34;
    localparam logic [7:0] OFF_HASH_LO    = 8'h80;
    localparam logic [7:0] OFF_HASH_HI    = 8'h84;
    localparam logic [7:0] OFF_SA1_LO     = 8'h98;
    localparam logic [7:0] OFF_SA1_HI     = 8'h9c;
    localparam logic [7:0] SA_STRIDE      = 8'h08;
    localparam int unsigned NUM_SA        = 4;

    localparam int unsigned CTRL_TXEN_BIT = 3;
    localparam int unsigned CFG_WC_BIT    = 1;
    localparam int unsigned CFG_HASH_BIT  = 7;
    localparam int unsigned CFG_DIV_LSB   = 16;
    localparam int unsigned CFG_DIV_W     = 3;
    localparam int unsigned STAT_IDLE_BIT = 2;
    localparam int unsigned MT_OP_LSB     = 28;
    localparam logic [1:0]  OP_WRITE      = 2'b01;
    localparam logic [1:0]  OP_READ       = 2'b10;
    localparam logic [2:0]  DIV_NOMINAL   = 3'b010;

    localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
    localparam logic [31:0] CFG_RST       = 32'h0002_0000;
    localparam logic [31:0] TXQ_RST       = 32'h0000_0000;

    localparam int unsigned IRQ_NUM       = 18;
    localparam int unsigned IRQ_MGMT_BIT  = 0;
    localparam logic [31:0] DESC_BYTES    = 32'h0000_0008;

    localparam int unsigned PREAMBLE_BITS = 32;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned MGMT_NOM_CYC  = 2000;
    localparam int unsigned MGMT_TOL_CYC  = 100;
    localparam int unsigned MDC_MIN_NS    = 400;
    localparam int unsigned MDC_MIN_CYC   =
        (MDC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic mdc;
        logic mdio_o;
        logic mdio_oe;
    } mpm_mdio_t;

    // half period of mdc in main-clock cycles per divider code
    function automatic logic [7:0] mpm_mdc_half(input logic [2:0] sel);
        logic [7:0] h;
        h = 8'h04;
        case (sel)
            3'b000: h = 8'h04;
            3'b001: h = 8'h08;
            3'b010: h = 8'h10;
            3'b011: h = 8'h18;
            3'b100: h = 8'h20;
            3'b101: h = 8'h30;
            3'b110: h = 8'h40;
            default: h = 8'h70;
        endcase
        return h;
    endfunction : mpm_mdc_half
endpackage : mpm_pkg

//--- tb_top.sv
// Purpose: self-checking bench for the mac control slice
// Assumes: apb master per the bus rules, divider code 010
// Notes:   phy partner answers read frames with a fixed word
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mpm_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, start, err;
    logic        pready, pslverr, rx_match_q, rx_to_screen_q, tx_en_q, irq;
    logic        rx_da_valid, tx_desc_adv, tx_desc_wrap, mdio_wire;
    logic [31:0] paddr, pwdata, prdata, rd, tx_desc_addr_q, cap, wd;
    logic [47:0] rx_da;
    logic [16:0] ext_events;
    mpm_mdio_t   mdio_pins;
    int          n_mismatch, tests_run, cyc, t0;

    mpm_mac_ctrl mpm_mac_ctrl_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_da_valid(rx_da_valid), .rx_da(rx_da), .rx_match_q(rx_match_q),
        .rx_to_screen_q(rx_to_screen_q), .tx_en_q(tx_en_q),
        .tx_desc_adv(tx_desc_adv), .tx_desc_wrap(tx_desc_wrap),
        .tx_desc_addr_q(tx_desc_addr_q), .ext_events(ext_events), .irq(irq),
        .mdio_in(mdio_wire), .mdio_pins(mdio_pins));
    mpm_phy_model mpm_phy_model_inst (.presetn(presetn), .start(start),
        .pins(mdio_pins), .rd_data(16'hbeef), .mdio_wire(mdio_wire),
        .cap_q(cap));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) cyc++;

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [31:0] a, d);
        int i;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (i >= 50) begin
            n_mismatch++;
            wrap_up();
        end
    endtask : apb

    task automatic pulse(input int sel, input logic [47:0] v);
        @(posedge pclk);
        rx_da_valid <= (sel == 0); rx_da <= v;
        tx_desc_adv <= (sel == 1 || sel == 2); tx_desc_wrap <= (sel == 2);
        ext_events <= (sel == 3) ? 17'h00020 : 17'h0;
        @(posedge pclk);
        {rx_da_valid, tx_desc_adv, tx_desc_wrap} <= 3'b000;
        ext_events <= 17'h0;
        #1;
    endtask : pulse

    task automatic mgmt(input logic [31:0] w, fin);
        int i;
        start <= 1'b1;
        apb(1'b1, 32'(OFF_MAINT), w);
        t0 = cyc;
        start <= 1'b0;
        apb(1'b0, 32'(OFF_STAT), 0);
        chk("idle_low", 32'(rd[STAT_IDLE_BIT]), 0);
        repeat (1200) @(posedge pclk);
        apb(1'b0, 32'(OFF_MAINT), 0);
        chk("partial", 32'(rd !== w && rd !== fin), 1);
        i = 0;
        do begin
            apb(1'b0, 32'(OFF_STAT), 0);
            i++;
        end while (rd[STAT_IDLE_BIT] !== 1'b1 && i < 1000);
        if (i >= 1000) begin
            n_mismatch++;
            wrap_up();
        end
        chk("span", 32'(cyc - t0 > 1900 && cyc - t0 < 2200), 1);
        apb(1'b0, 32'(OFF_ISR), 0);
        chk("isr_mgmt", 32'(rd[IRQ_MGMT_BIT]), 1);
        apb(1'b0, 32'(OFF_MAINT), 0);
        chk("maint_end", rd, fin);
        chk("mdio_frame", cap, fin);
        $display("test mgmt %h done", w);
    endtask : mgmt

    initial begin
        {psel, penable, pwrite, start, rx_da_valid} = 5'b0;
        {tx_desc_adv, tx_desc_wrap, paddr, pwdata} = '0;
        rx_da = '0;
        ext_events = '0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 32'(OFF_CFG), 0);
        chk("cfg_reset", rd, CFG_RST);
        apb(1'b0, 32'(OFF_STAT), 0);
        chk("idle_reset", 32'(rd[STAT_IDLE_BIT]), 1);
        apb(1'b1, 32'h0000_0104, 32'hffff_ffff);
        chk("unmapped", 32'(err), 1);
        apb(1'b0, 32'(OFF_CFG), 0);
        chk("cfg_kept", rd, CFG_RST);
        $display("test reset done");
        apb(1'b1, 32'(OFF_SA1_LO), 32'h8765_4321);
        apb(1'b1, 32'(OFF_SA1_HI), 32'h0000_cba9);
        pulse(0, 48'hcba9_8765_4321);
        chk("match", 32'(rx_match_q), 1);
        chk("screen", 32'(rx_to_screen_q), 1);
        apb(1'b1, 32'(OFF_SA1_LO), 32'h8765_4321);
        pulse(0, 48'hcba9_8765_4321);
        chk("suspended", 32'(rx_match_q | rx_to_screen_q), 0);
        apb(1'b1, 32'(OFF_SA1_HI), 32'h0000_cba9);
        pulse(0, 48'hcba9_8765_4321);
        chk("resumed", 32'(rx_match_q), 1);
        apb(1'b1, 32'(OFF_HASH_LO), 32'hffff_ffff);
        apb(1'b1, 32'(OFF_HASH_HI), 32'hffff_ffff);
        apb(1'b1, 32'(OFF_CFG), CFG_RST | (32'h1 << CFG_HASH_BIT));
        pulse(0, 48'h0000_0000_0001);
        chk("hash", 32'(rx_match_q), 1);
        $display("test match done");
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, 32'(OFF_CFG), CFG_RST | (32'(m) << CFG_WC_BIT));
            pulse(3, 48'h0);
            chk("irq_set", 32'(irq), 1);
            apb(1'b0, 32'(OFF_ISR), 0);
            chk("isr_bit", rd, 32'h40);
            if (m == 1) apb(1'b1, 32'(OFF_ISR), 32'h40);
            apb(1'b0, 32'(OFF_ISR), 0);
            chk("isr_clear", rd, 0);
            chk("irq_clear", 32'(irq), 0);
        end
        apb(1'b1, 32'(OFF_CFG), CFG_RST);
        $display("test irq done");
        apb(1'b1, 32'(OFF_TXQ), 32'h0000_1000);
        apb(1'b1, 32'(OFF_CTRL), 32'h0000_0008);
        repeat (2) @(posedge pclk);
        chk("tx_en", 32'(tx_en_q), 1);
        chk("desc_base", tx_desc_addr_q, 32'h1000);
        pulse(1, 48'h0);
        chk("desc_next", tx_desc_addr_q, 32'h1000 + DESC_BYTES);
        pulse(2, 48'h0);
        chk("desc_wrap", tx_desc_addr_q, 32'h1000);
        $display("test tx done");
        wd = {2'b01, OP_WRITE, 5'd3, 5'd4, 2'b10, 16'ha5c3};
        mgmt(wd, wd);
        wd = {2'b01, OP_READ, 5'd3, 5'd2, 2'b10, 16'h0000};
        mgmt(wd, {wd[31:16], 16'hbeef});
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
